// >>> hdl/word_move_pkg.sv
// Shared types, memory map and helper functions for the word data movement unit
package word_move_pkg;

    localparam int AW        = 14;
    localparam int MEM_WORDS = 16384;

    // Flat word map of the controller's memory areas
    localparam logic [AW:0] GEN_BASE = 15'h0000;
    localparam logic [AW:0] TC_BASE  = 15'h0800;
    localparam logic [AW:0] DM_BASE  = 15'h1000;
    localparam logic [AW:0] EM_BASE  = 15'h2a00;
    localparam logic [AW:0] MAP_END  = 15'h4000;

    localparam logic [3:0] DIGIT_SINGLE_MAX = 4'h8;
    localparam logic [3:0] DIGIT_STACK      = 4'h9;

    typedef enum logic [1:0] {
        AREA_GEN,
        AREA_TC,
        AREA_DM,
        AREA_EM
    } area_e;

    typedef enum logic [2:0] {
        OP_PLAIN_WORD_COPY,
        OP_INVERTED_WORD_COPY,
        OP_BLOCK_COPY,
        OP_BLOCK_FILL,
        OP_WORD_SWAP,
        OP_DISTRIBUTE
    } op_e;

    typedef struct packed {
        logic          ok;
        area_e         id;
        logic [AW:0]   base;
        logic [AW:0]   size;
    } area_s;

    // aux: word count, end word, second swap word or control word, by operation
    typedef struct packed {
        op_e           op;
        logic [AW-1:0] src;
        logic          src_ind;
        logic          src_imm;
        logic [15:0]   src_val;
        logic [AW-1:0] dst;
        logic          dst_ind;
        logic [AW-1:0] aux;
        logic          aux_ind;
        logic          aux_imm;
        logic [15:0]   aux_val;
    } move_req_s;

    function automatic area_s area_of(input logic [AW:0] a);
        area_s r;
        r = '0;
        if (a < TC_BASE)
        begin
            r = '{1'b1, AREA_GEN, GEN_BASE, TC_BASE - GEN_BASE};
        end
        else if (a < DM_BASE)
        begin
            r = '{1'b1, AREA_TC, TC_BASE, DM_BASE - TC_BASE};
        end
        else if (a < EM_BASE)
        begin
            r = '{1'b1, AREA_DM, DM_BASE, EM_BASE - DM_BASE};
        end
        else if (a < MAP_END)
        begin
            r = '{1'b1, AREA_EM, EM_BASE, MAP_END - EM_BASE};
        end
        return r;
    endfunction

    // True when both addresses exist and lie in one area
    function automatic logic same_area(input logic [AW:0] a, input logic [AW:0] b);
        area_s ra;
        area_s rb;
        ra = area_of(a);
        rb = area_of(b);
        return ra.ok && rb.ok && (ra.id == rb.id);
    endfunction

    // Four-digit decimal increment, wraps 9999 to 0000
    function automatic logic [15:0] bcd_inc(input logic [15:0] v);
        logic [15:0] r;
        logic        carry;
        r     = v;
        carry = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            if (carry)
            begin
                if (r[4*i +: 4] >= 4'h9)
                begin
                    r[4*i +: 4] = 4'h0;
                end
                else
                begin
                    r[4*i +: 4] = r[4*i +: 4] + 4'h1;
                    carry       = 1'b0;
                end
            end
        end
        return r;
    endfunction

endpackage

// >>> hdl/bcd_word_decode.sv
// Four-digit decimal word check and conversion to binary
`timescale 1ns/10ps
module bcd_word_decode
    import word_move_pkg::*;
(
    input  wire logic [15:0] word,
    output      logic        digits_ok,
    output      logic [13:0] value
);

    always_comb
    begin
        digits_ok = (word[15:12] <= 4'h9) && (word[11:8] <= 4'h9)
                 && (word[7:4] <= 4'h9) && (word[3:0] <= 4'h9);
        value     = 14'(word[15:12]) * 14'd1000 + 14'(word[11:8]) * 14'd100
                  + 14'(word[7:4]) * 14'd10 + 14'(word[3:0]);
    end

endmodule

// >>> hdl/word_data_movement_unit.sv
// Word data movement unit: copies, fills, swaps and distributes words in memory
//
// What this block does, and what the program must do itself
// RULE1: Plain copy writes source when condition true only
// RULE2: Copies set zero flag on all-zero result; block copy leaves the zero flag unchanged
// RULE3: Inverted copy writes bitwise complement of source
// RULE4: Program never targets reserved data memory words
// RULE5: Program never copies into timer/counter values
// RULE6: Block copy moves source range to destination
// RULE7: Block copy errors on non-decimal word count
// RULE8: Block copy errors when range crosses areas
// RULE9: Block fill writes source into start..end
// RULE10: Fill errors on split areas or start>end
// RULE11: Block fill may target timer/counter words
// RULE12: Word swap exchanges both words at once
// RULE13: Bad indirect pointer raises error for all
// RULE14: Top digit 0..8 selects single-word offset mode
// RULE15: Single mode writes source at base+offset
// RULE16: Top digit 9 selects stack mode
// RULE17: Stack writes base+1+pointer, then bumps pointer
// RULE18: Distribute errors on non-decimal offset/length
// RULE19: Stack errors when pointer+1 exceeds length
// RULE20: Distribute zero flag follows source zero
// RULE21: Level form each scan, edge form once
// RULE22: Program preloads stack pointer before stacking
// RULE23: Errors leave memory untouched; success clears error
`timescale 1ns/10ps
module word_data_movement_unit
    import word_move_pkg::*;
(
    input  wire logic          mclk,
    input  wire logic          rst_n,
    input  wire logic          scan_strobe,
    input  wire logic          exec_cond,
    input  wire logic          edge_mode,
    input  wire move_req_s     req,
    input  wire logic          host_we,
    input  wire logic [AW-1:0] host_addr,
    input  wire logic [15:0]   host_wdata,
    output      logic [15:0]   host_rdata,
    output      logic          busy,
    output      logic          done,
    output      logic          error_flag,
    output      logic          zero_flag
);

    typedef enum logic [2:0] {
        S_IDLE,
        S_RESOLVE,
        S_CHECK,
        S_LOOP,
        S_FINISH
    } state_e;

    localparam int NDEC = 6;

    logic [15:0]   mem [0:MEM_WORDS-1];

    state_e        state_q;
    move_req_s     req_q;
    logic          cond_prev_q;
    logic [AW-1:0] sa_q;
    logic [AW-1:0] da_q;
    logic [AW-1:0] xa_q;
    logic [15:0]   sv_q;
    logic [AW-1:0] idx_q;
    logic [AW-1:0] n_q;
    logic          err_q;
    logic          zero_upd_q;
    logic          zero_val_q;
    logic          busy_q;
    logic          done_q;
    logic          error_flag_q;
    logic          zero_flag_q;
    logic [15:0]   host_rdata_q;

    logic          fire;
    logic [15:0]   dec_in [NDEC];
    logic          dec_ok [NDEC];
    logic [13:0]   dec_val [NDEC];

    logic [AW-1:0] opnd_addr [3];
    logic          opnd_ind [3];
    logic [AW-1:0] res_addr [3];
    logic          res_err;

    logic [15:0]   sv;
    logic [15:0]   ctrl;
    logic          chk_err;
    logic          wr1_en;
    logic [AW-1:0] wr1_addr;
    logic [15:0]   wr1_data;
    logic          wr2_en;
    logic [AW-1:0] wr2_addr;
    logic [15:0]   wr2_data;
    logic          loop_go;
    logic [AW-1:0] loop_n;
    logic          zero_upd;
    logic          zero_val;
    logic [AW-1:0] loop_addr;
    logic [15:0]   loop_data;

    // Edge form compares against the condition seen at the previous scan
    always_comb
    begin
        fire = scan_strobe && exec_cond && (!edge_mode || !cond_prev_q) // RULE21
            && (state_q == S_IDLE);
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cond_prev_q <= 1'b0;
        end
        else if (scan_strobe)
        begin
            cond_prev_q <= exec_cond;
        end
    end

    assign opnd_addr[0] = req_q.src;
    assign opnd_addr[1] = req_q.dst;
    assign opnd_addr[2] = req_q.aux;
    assign opnd_ind[0]  = req_q.src_ind && !req_q.src_imm;
    assign opnd_ind[1]  = req_q.dst_ind;
    assign opnd_ind[2]  = req_q.aux_ind && !req_q.aux_imm;

    assign sv   = req_q.src_imm ? req_q.src_val : mem[sa_q];
    assign ctrl = req_q.aux_imm ? req_q.aux_val : mem[xa_q];

    assign dec_in[0] = mem[req_q.src];
    assign dec_in[1] = mem[req_q.dst];
    assign dec_in[2] = mem[req_q.aux];
    assign dec_in[3] = ctrl;
    assign dec_in[4] = {4'h0, ctrl[11:0]};
    assign dec_in[5] = mem[da_q];

    generate
        for (genvar g = 0; g < NDEC; g++)
        begin : g_dec
            bcd_word_decode u_dec (
                .word      (dec_in[g]),
                .digits_ok (dec_ok[g]),
                .value     (dec_val[g])
            );
        end
    endgenerate

    // Indirect operands: pointer word must be decimal and stay inside its area
    always_comb
    begin
        area_s ar;
        ar      = '0;
        res_err = 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            ar          = area_of({1'b0, opnd_addr[i]});
            res_addr[i] = opnd_addr[i];
            if (opnd_ind[i])
            begin
                if (!((ar.id == AREA_DM) || (ar.id == AREA_EM)) || !dec_ok[i]
                    || ({1'b0, dec_val[i]} >= ar.size))
                begin
                    res_err = 1'b1; // RULE13
                end
                res_addr[i] = AW'(ar.base + {1'b0, dec_val[i]});
            end
        end
    end

    always_comb
    begin
        logic [AW:0] end_s;
        logic [AW:0] end_d;
        logic [AW:0] tgt;
        end_s    = '0;
        end_d    = '0;
        tgt      = '0;
        chk_err  = 1'b0;
        wr1_en   = 1'b0;
        wr1_addr = da_q;
        wr1_data = sv;
        wr2_en   = 1'b0;
        wr2_addr = xa_q;
        wr2_data = mem[da_q];
        loop_go  = 1'b0;
        loop_n   = '0;
        zero_upd = 1'b0;
        zero_val = 1'b0;
        unique case (req_q.op)
            OP_PLAIN_WORD_COPY:
            begin
                wr1_en   = 1'b1; // RULE1
                zero_upd = 1'b1;
                zero_val = (sv == 16'h0000); // RULE2
            end
            OP_INVERTED_WORD_COPY:
            begin
                wr1_en   = 1'b1;
                wr1_data = ~sv; // RULE3
                zero_upd = 1'b1;
                zero_val = (~sv == 16'h0000); // RULE2
            end
            OP_BLOCK_COPY:
            begin
                end_s   = {1'b0, sa_q} + {1'b0, dec_val[3]};
                end_d   = {1'b0, da_q} + {1'b0, dec_val[3]};
                chk_err = !dec_ok[3] // RULE7
                       || !same_area({1'b0, sa_q}, end_s)
                       || !same_area({1'b0, da_q}, end_d); // RULE8
                loop_go = 1'b1; // RULE6
                loop_n  = AW'(dec_val[3]);
            end
            OP_BLOCK_FILL:
            begin
                // Timer/counter words are ordinary targets here
                chk_err = !same_area({1'b0, da_q}, {1'b0, xa_q}) || (da_q > xa_q); // RULE10 RULE11
                loop_go = 1'b1; // RULE9
                loop_n  = xa_q - da_q;
            end
            OP_WORD_SWAP:
            begin
                wr1_en   = 1'b1; // RULE12
                wr1_data = mem[xa_q];
                wr2_en   = 1'b1;
                wr2_addr = xa_q;
                wr2_data = mem[da_q];
            end
            OP_DISTRIBUTE:
            begin
                zero_upd = 1'b1;
                zero_val = (sv == 16'h0000); // RULE20
                if (ctrl[15:12] <= DIGIT_SINGLE_MAX) // RULE14
                begin
                    tgt      = {1'b0, da_q} + {1'b0, dec_val[3]}; // RULE15
                    chk_err  = !dec_ok[3] || !same_area({1'b0, da_q}, tgt); // RULE18
                    wr1_en   = 1'b1;
                    wr1_addr = AW'(tgt);
                end
                else if (ctrl[15:12] == DIGIT_STACK) // RULE16
                begin
                    tgt      = {1'b0, da_q} + 15'h0001 + {1'b0, dec_val[5]}; // RULE17
                    chk_err  = !dec_ok[4] || !dec_ok[5] // RULE18
                            || ({1'b0, dec_val[5]} + 15'h0001 > {1'b0, dec_val[4]}) // RULE19
                            || !same_area({1'b0, da_q}, tgt);
                    wr1_en   = 1'b1;
                    wr1_addr = AW'(tgt);
                    wr2_en   = 1'b1;
                    wr2_addr = da_q;
                    wr2_data = bcd_inc(mem[da_q]); // RULE17
                end
                else
                begin
                    chk_err = 1'b1; // RULE18
                end
            end
        endcase
    end

    assign loop_addr = AW'(da_q + idx_q);
    assign loop_data = (req_q.op == OP_BLOCK_COPY) ? mem[AW'(sa_q + idx_q)] : sv_q;

    // Ascending order: an overlapping copy to a higher address smears the first words
    always_ff @(posedge mclk)
    begin
        if ((state_q == S_IDLE) && host_we)
        begin
            mem[host_addr] <= host_wdata;
        end
        if ((state_q == S_CHECK) && !chk_err) // RULE23
        begin
            if (wr1_en)
            begin
                mem[wr1_addr] <= wr1_data;
            end
            if (wr2_en)
            begin
                mem[wr2_addr] <= wr2_data;
            end
        end
        if (state_q == S_LOOP)
        begin
            mem[loop_addr] <= loop_data;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= S_IDLE;
            req_q   <= '0;
            sa_q    <= '0;
            da_q    <= '0;
            xa_q    <= '0;
            sv_q    <= '0;
            idx_q   <= '0;
            n_q     <= '0;
            err_q   <= 1'b0;
            zero_upd_q <= 1'b0;
            zero_val_q <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                S_IDLE:
                begin
                    if (fire)
                    begin
                        req_q   <= req;
                        state_q <= S_RESOLVE;
                    end
                end
                S_RESOLVE:
                begin
                    sa_q       <= res_addr[0];
                    da_q       <= res_addr[1];
                    xa_q       <= res_addr[2];
                    err_q      <= res_err;
                    zero_upd_q <= 1'b0;
                    state_q    <= res_err ? S_FINISH : S_CHECK;
                end
                S_CHECK:
                begin
                    err_q      <= chk_err;
                    zero_upd_q <= zero_upd && !chk_err;
                    zero_val_q <= zero_val;
                    sv_q       <= sv;
                    idx_q      <= '0;
                    n_q        <= loop_n;
                    state_q    <= (loop_go && !chk_err) ? S_LOOP : S_FINISH;
                end
                S_LOOP:
                begin
                    idx_q <= idx_q + 1'b1;
                    if (idx_q == n_q)
                    begin
                        state_q <= S_FINISH;
                    end
                end
                S_FINISH:
                begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy_q       <= 1'b0;
            done_q       <= 1'b0;
            error_flag_q <= 1'b0;
            zero_flag_q  <= 1'b0;
        end
        else
        begin
            busy_q <= fire || ((state_q != S_IDLE) && (state_q != S_FINISH));
            done_q <= (state_q == S_FINISH);
            if (state_q == S_FINISH)
            begin
                error_flag_q <= err_q; // RULE23
                if (zero_upd_q)
                begin
                    zero_flag_q <= zero_val_q;
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            host_rdata_q <= 16'h0000;
        end
        else
        begin
            host_rdata_q <= mem[host_addr];
        end
    end

    assign host_rdata = host_rdata_q;
    assign busy       = busy_q;
    assign done       = done_q;
    assign error_flag = error_flag_q;
    assign zero_flag  = zero_flag_q;

endmodule

// >>> verif/word_move_assertions.sv
// Port-level checker for the word data movement unit
`timescale 1ns/10ps
module word_move_checker
    import word_move_pkg::*;
(
    input wire logic          mclk,
    input wire logic          rst_n,
    input wire logic          scan_strobe,
    input wire logic          exec_cond,
    input wire logic          edge_mode,
    input wire move_req_s     req,
    input wire logic          host_we,
    input wire logic [AW-1:0] host_addr,
    input wire logic [15:0]   host_wdata,
    input wire logic [15:0]   host_rdata,
    input wire logic          busy,
    input wire logic          done,
    input wire logic          error_flag,
    input wire logic          zero_flag
);
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    logic      prev_q;
    move_req_s cap_q;
    wire logic fire = scan_strobe && exec_cond && !busy && (!edge_mode || !prev_q);
    wire logic one_word = req.op inside {OP_PLAIN_WORD_COPY, OP_INVERTED_WORD_COPY,
                                         OP_WORD_SWAP, OP_DISTRIBUTE};

    function automatic logic bad_bcd(input logic [15:0] v);
        return v[15:12] > 4'h9 || v[11:8] > 4'h9 || v[7:4] > 4'h9 || v[3:0] > 4'h9;
    endfunction

    // Mirrors the condition memory, kept across refused scans too
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prev_q <= 1'b0;
        end
        else if (scan_strobe)
        begin
            prev_q <= exec_cond;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (fire)
        begin
            cap_q <= req;
        end
    end

    start_busy_a: assert property (fire |=> busy)
        else $error("busy did not follow an accepted scan");
    cond_off_a: assert property (scan_strobe && !exec_cond && !busy |=> !busy)
        else $error("operation started with condition false");
    word_latency_a: assert property (fire && one_word |=> !done ##1 !done ##[1:2] done)
        else $error("single word operation latency wrong");
    busy_end_a: assert property (done |-> !busy && $past(busy))
        else $error("done without busy ending");
    flag_hold_a: assert property (!done |-> $stable(error_flag) && $stable(zero_flag))
        else $error("flags changed outside done");
    zero_plain_a: assert property (done && !error_flag && cap_q.src_imm
        && cap_q.op == OP_PLAIN_WORD_COPY |-> zero_flag == (cap_q.src_val == 16'h0000))
        else $error("plain copy zero flag wrong");
    zero_inv_a: assert property (done && !error_flag && cap_q.src_imm
        && cap_q.op == OP_INVERTED_WORD_COPY |-> zero_flag == (cap_q.src_val == 16'hffff))
        else $error("inverted copy zero flag wrong");
    zero_dist_a: assert property (done && !error_flag && cap_q.src_imm
        && cap_q.op == OP_DISTRIBUTE |-> zero_flag == (cap_q.src_val == 16'h0000))
        else $error("distribute zero flag wrong");
    bad_count_a: assert property (done && cap_q.op == OP_BLOCK_COPY && cap_q.aux_imm
        && bad_bcd(cap_q.aux_val) |-> error_flag)
        else $error("non-decimal count accepted");
    bad_ctrl_a: assert property (done && cap_q.op == OP_DISTRIBUTE && cap_q.aux_imm
        && bad_bcd(cap_q.aux_val) |-> error_flag)
        else $error("non-decimal control word accepted");
    fill_order_a: assert property (done && cap_q.op == OP_BLOCK_FILL && !cap_q.dst_ind
        && !cap_q.aux_ind && cap_q.dst > cap_q.aux |-> error_flag)
        else $error("reversed fill range accepted");

    cover property (fire && req.op == OP_DISTRIBUTE);
    cover property (done && error_flag);
    cover property (scan_strobe && exec_cond && edge_mode && prev_q && !busy);
endmodule

bind word_data_movement_unit word_move_checker chk_u (.mclk(mclk), .rst_n(rst_n),
    .scan_strobe(scan_strobe), .exec_cond(exec_cond), .edge_mode(edge_mode), .req(req),
    .host_we(host_we), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .busy(busy), .done(done), .error_flag(error_flag),
    .zero_flag(zero_flag));

// >>> verif/tb_top.sv
// Self-checking bench for the word data movement unit
`timescale 1ns/10ps
module tb_top
    import word_move_pkg::*;
();
    typedef struct packed {
        move_req_s     r;
        logic          e;
        logic [AW-1:0] ca;
        logic [15:0]   cv;
    } row_s;

    logic          mclk = 1'b0;
    logic          rst_n = 1'b0;
    logic          scan_strobe = 1'b0;
    logic          exec_cond = 1'b0;
    logic          edge_mode = 1'b0;
    logic          host_we = 1'b0;
    move_req_s     req = '0;
    logic [AW-1:0] host_addr = '0;
    logic [15:0]   host_wdata = '0;
    logic [15:0]   host_rdata;
    logic          busy;
    logic          done;
    logic          error_flag;
    logic          zero_flag;
    int            n_mismatch = 0;
    int            checks_done = 0;
    int            cycles = 0;
    int            n_done = 0;
    int            n;
    row_s          rows[16];
    move_req_s     r;

    word_data_movement_unit dut_u (.mclk(mclk), .rst_n(rst_n), .scan_strobe(scan_strobe),
        .exec_cond(exec_cond), .edge_mode(edge_mode), .req(req), .host_we(host_we),
        .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
        .busy(busy), .done(done), .error_flag(error_flag), .zero_flag(zero_flag));

    always #2.5 mclk = ~mclk;

    // Whole run is a few hundred cycles; the ceiling only cuts a hang short
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (done === 1'b1)
            n_done <= n_done + 1;
        if (cycles == 20000)
        begin
            n_mismatch++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic move_req_s mk(input op_e o, input logic si, input logic [15:0] s,
                                     input logic [AW-1:0] d, input logic ai,
                                     input logic [15:0] a);
        move_req_s q;
        q = '0;
        q.op = o;
        q.src_imm = si;
        q.src = s[AW-1:0];
        q.src_val = s;
        q.dst = d;
        q.aux_imm = ai;
        q.aux = a[AW-1:0];
        q.aux_val = a;
        return q;
    endfunction

    task automatic wr(input logic [AW-1:0] a, input logic [15:0] d);
        @(posedge mclk);
        host_we <= 1'b1;
        host_addr <= a;
        host_wdata <= d;
        @(posedge mclk);
        host_we <= 1'b0;
    endtask

    task automatic see(input logic [AW-1:0] a, input logic [15:0] exp);
        @(posedge mclk);
        host_addr <= a;
        repeat (2) @(posedge mclk);
        #1 chk(host_rdata, exp);
    endtask

    // Waits a bounded time; a refused scan simply never sees done
    task automatic run(input move_req_s q, input logic c);
        @(posedge mclk);
        scan_strobe <= 1'b1;
        exec_cond <= c;
        req <= q;
        @(posedge mclk);
        scan_strobe <= 1'b0;
        #1;
        for (int k = 0; k < 40 && done !== 1'b1; k++)
        begin
            @(posedge mclk);
            #1;
        end
    endtask

    initial
    begin
        rows[0]  = '{mk(OP_PLAIN_WORD_COPY, 1'b1, 16'h1234, 14'h0010, 1'b0, 16'h0),
                     1'b0, 14'h0010, 16'h1234};
        rows[1]  = '{mk(OP_PLAIN_WORD_COPY, 1'b1, 16'h0000, 14'h0011, 1'b0, 16'h0),
                     1'b0, 14'h0011, 16'h0000};
        rows[2]  = '{mk(OP_INVERTED_WORD_COPY, 1'b1, 16'hf8c5, 14'h1010, 1'b0, 16'h0),
                     1'b0, 14'h1010, 16'h073a};
        rows[3]  = '{mk(OP_INVERTED_WORD_COPY, 1'b1, 16'hffff, 14'h0012, 1'b0, 16'h0),
                     1'b0, 14'h0012, 16'h0000};
        rows[4]  = '{mk(OP_BLOCK_COPY, 1'b0, 16'h0200, 14'h0300, 1'b1, 16'h0002),
                     1'b0, 14'h0302, 16'h3333};
        rows[5]  = '{mk(OP_BLOCK_COPY, 1'b0, 16'h0200, 14'h0400, 1'b1, 16'h001a),
                     1'b1, 14'h0400, 16'haaaa};
        rows[6]  = '{mk(OP_BLOCK_COPY, 1'b0, 16'h07ff, 14'h0401, 1'b1, 16'h0001),
                     1'b1, 14'h0401, 16'h5555};
        rows[7]  = '{mk(OP_BLOCK_FILL, 1'b1, 16'habcd, 14'h0800, 1'b0, 16'h0802),
                     1'b0, 14'h0802, 16'habcd};
        rows[8]  = '{mk(OP_BLOCK_FILL, 1'b1, 16'habcd, 14'h0805, 1'b0, 16'h0803),
                     1'b1, 14'h0803, 16'h4444};
        rows[9]  = '{mk(OP_BLOCK_FILL, 1'b1, 16'habcd, 14'h0ffe, 1'b0, 16'h1001),
                     1'b1, 14'h1000, 16'h0000};
        rows[10] = '{mk(OP_WORD_SWAP, 1'b0, 16'h0, 14'h0400, 1'b0, 16'h0401),
                     1'b0, 14'h0400, 16'h5555};
        rows[11] = '{mk(OP_DISTRIBUTE, 1'b1, 16'h00ff, 14'h0100, 1'b1, 16'h0005),
                     1'b0, 14'h0105, 16'h00ff};
        rows[12] = '{mk(OP_DISTRIBUTE, 1'b1, 16'hffff, 14'h1000, 1'b1, 16'h9005),
                     1'b0, 14'h1001, 16'hffff};
        rows[13] = '{mk(OP_DISTRIBUTE, 1'b1, 16'h0000, 14'h1000, 1'b1, 16'h9005),
                     1'b0, 14'h1002, 16'h0000};
        rows[14] = '{mk(OP_DISTRIBUTE, 1'b1, 16'h0007, 14'h0100, 1'b1, 16'h00a0),
                     1'b1, 14'h0105, 16'h00ff};
        rows[15] = '{mk(OP_DISTRIBUTE, 1'b1, 16'h0007, 14'h1200, 1'b1, 16'h9005),
                     1'b1, 14'h1200, 16'h0005};
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        #1 chk(16'({busy, done, error_flag, zero_flag}), 16'h0000);
        wr(14'h0200, 16'h1111);
        wr(14'h0201, 16'h2222);
        wr(14'h0202, 16'h3333);
        wr(14'h0400, 16'haaaa);
        wr(14'h0401, 16'h5555);
        wr(14'h0803, 16'h4444);
        wr(14'h1000, 16'h0000);
        wr(14'h1200, 16'h0005);
        wr(14'h1100, 16'h00f0);
        foreach (rows[i])
        begin
            run(rows[i].r, 1'b1);
            chk(16'(done), 16'h0001);
            chk(16'(error_flag), 16'(rows[i].e));
            if (!rows[i].e && rows[i].r.op inside {OP_PLAIN_WORD_COPY, OP_INVERTED_WORD_COPY,
                OP_DISTRIBUTE})
                chk(16'(zero_flag), 16'(rows[i].cv == 16'h0000));
            see(rows[i].ca, rows[i].cv);
            $display("row %0d ended", i);
        end
        see(14'h0401, 16'haaaa);
        see(14'h0300, 16'h1111);
        see(14'h1000, 16'h0002);
        $display("pointer test ended");
        r = mk(OP_PLAIN_WORD_COPY, 1'b1, 16'h1234, 14'h1100, 1'b0, 16'h0);
        r.dst_ind = 1'b1;
        run(r, 1'b1);
        chk(16'(error_flag), 16'h0001);
        $display("indirect test ended");
        // The done counter lags done by one edge; let the last count land first
        repeat (2) @(posedge mclk);
        n = n_done;
        run(mk(OP_PLAIN_WORD_COPY, 1'b1, 16'h9999, 14'h0010, 1'b0, 16'h0), 1'b0);
        chk(16'(n_done - n), 16'h0000);
        see(14'h0010, 16'h1234);
        $display("condition test ended");
        @(posedge mclk);
        edge_mode <= 1'b1;
        n = n_done;
        run(mk(OP_PLAIN_WORD_COPY, 1'b1, 16'h0001, 14'h0013, 1'b0, 16'h0), 1'b1);
        run(mk(OP_PLAIN_WORD_COPY, 1'b1, 16'h0002, 14'h0013, 1'b0, 16'h0), 1'b1);
        chk(16'(n_done - n), 16'h0001);
        see(14'h0013, 16'h0001);
        $display("edge test ended");
        wrap_up();
    end
endmodule
